// >>> design/tls_cfg.svh
// Constants for the transient level sequencer
`ifndef TLS_CFG_SVH
`define TLS_CFG_SVH
// Timing
`define TLS_CLK_PERIOD_NS 4
`define TLS_TICK_NS 1000
`define TLS_TICK_CYC (`TLS_TICK_NS / `TLS_CLK_PERIOD_NS)
`define TLS_TICK_W 8
// Scale factors
`define TLS_US_PER_S 40'h00000f4240
`define TLS_MS_PER_S 40'h00000003e8
`define TLS_ONE_PS 40'h0000000001
`define TLS_BW_DIV 40'h00000003e8
`define TLS_PCT 32'h00000064
`define TLS_FRAC 16
// Duty range
`define TLS_DUTY_MIN 7'h01
`define TLS_DUTY_MAX 7'h63
// Reset values: 1 Hz, 50 %
`define TLS_RST_PERIOD_US 32'h000f4240
`define TLS_RST_DUTY 7'h32
// Slew limits and calibrated default, level LSB per second
`define TLS_SLEW_DEF_PS 40'h0000989680
`define TLS_SLEW_MAX_CC 40'h001dcd6500
`define TLS_SLEW_MAX_CP 40'h000bebc200
`define TLS_SLEW_MAX_CG 40'h0005f5e100
`define TLS_SLEW_MAX_CR 40'h0002faf080
`define TLS_SLEW_MIN_PS 40'h0000000001
`endif

// >>> design/tls_pkg.sv
// Types for the transient level sequencer
package tls_pkg;
   typedef enum logic [1:0] {
      constant_current_mode = 2'b00,
      constant_power_mode = 2'b01,
      constant_conductance_mode = 2'b10,
      constant_resistance_mode = 2'b11
   } tls_mode_t;
   typedef enum logic [1:0] {
      SEL_FIRST = 2'b00,
      SEL_SECOND = 2'b01,
      SEL_TRANS = 2'b10
   } tls_sel_t;
   typedef enum logic [1:0] {
      UNIT_PER_US = 2'b00,
      UNIT_PER_MS = 2'b01,
      UNIT_PER_S = 2'b10
   } tls_unit_t;
   typedef enum logic [1:0] {
      OSC_IDLE = 2'b00,
      OSC_FIRST = 2'b01,
      OSC_SECOND = 2'b10
   } tls_osc_t;
   typedef struct packed {
      logic [15:0] first_level;
      logic [15:0] second_level;
   } tls_levels_t;
   typedef struct packed {
      logic wr;
      logic is_period;
      logic [31:0] value;
   } tls_rate_cmd_t;
   typedef struct packed {
      logic wr;
      logic dflt;
      logic optimum;
      tls_unit_t unit;
      logic [15:0] value;
   } tls_slew_cmd_t;
endpackage

// >>> design/tls_sequencer.sv
// Transient level sequencer with slew limited setpoint
`timescale 1ns/1ps
`include "tls_cfg.svh"
module tls_sequencer (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   // Settings
   input wire tls_pkg::tls_mode_t MODE_IN,
   input wire tls_pkg::tls_levels_t LEVELS_IN,
   input wire tls_pkg::tls_sel_t LEVEL_SEL_IN,
   input wire logic EXT_TIMING_SEL_IN,
   input wire logic EXT_ANALOG_SEL_IN,
   input wire logic INPUT_ENABLE_IN,
   input wire logic SLOW_START_IN,
   input wire tls_pkg::tls_rate_cmd_t RATE_CMD_IN,
   input wire logic DUTY_WR_IN,
   input wire logic [6:0] DUTY_IN,
   input wire tls_pkg::tls_slew_cmd_t SLEW_CMD_IN,
   // Pins from outside the clock domain
   input wire logic EXT_TIMING_IN,
   input wire logic [15:0] EXT_ANALOG_IN,
   input wire logic ABOVE_DROPOUT_IN,
   // Power stage
   output logic [15:0] SETPOINT_OUT,
   output logic REDUCED_BW_OUT,
   // Status
   output logic TRANS_ACTIVE_OUT,
   output logic SLEW_WARNING_OUT,
   output logic CAL_STATE_OUT,
   output logic [31:0] TRANS_TIME_US_OUT,
   output logic SLEW_ERR_OUT,
   output logic RATE_ERR_OUT,
   output logic DUTY_ERR_OUT,
   output logic [39:0] SLEW_MIN_OUT,
   output logic [39:0] SLEW_MAX_OUT,
   output logic [39:0] SLEW_PS_OUT
);

   // ************************************************
   // Functions
   // ************************************************
   function automatic logic [39:0] slew_max(input tls_pkg::tls_mode_t m);
      logic [39:0] r;
      r = `TLS_SLEW_MAX_CC;
      unique case (m)
         tls_pkg::constant_current_mode: r = `TLS_SLEW_MAX_CC;
         tls_pkg::constant_power_mode: r = `TLS_SLEW_MAX_CP;
         tls_pkg::constant_conductance_mode: r = `TLS_SLEW_MAX_CG;
         tls_pkg::constant_resistance_mode: r = `TLS_SLEW_MAX_CR;
      endcase
      return r;
   endfunction

   // Normalise an entered rate to LSB per second
   function automatic logic [39:0] to_per_s(input tls_pkg::tls_unit_t u,
                                            input logic [15:0] v);
      logic [39:0] s;
      s = `TLS_ONE_PS;
      if (u == tls_pkg::UNIT_PER_US) begin
         s = `TLS_US_PER_S;
      end else if (u == tls_pkg::UNIT_PER_MS) begin
         s = `TLS_MS_PER_S;
      end
      return 40'(s * {24'h000000, v});
   endfunction

   // One step of the ramp toward a target, clamped
   function automatic logic [31:0] ramp_step(input logic [31:0] cur,
                                             input logic [31:0] tgt,
                                             input logic [31:0] inc);
      logic [32:0] up;
      logic [31:0] r;
      up = {1'b0, cur} + {1'b0, inc};
      r = tgt;
      if (cur < tgt) begin
         r = (up >= {1'b0, tgt}) ? tgt : up[31:0];
      end else if (cur > tgt) begin
         r = (cur - tgt <= inc) ? tgt : cur - inc;
      end
      return r;
   endfunction

   // ************************************************
   // Input synchronisers
   // ************************************************
   logic [1:0] ext_timing_sync;
   logic [15:0] ext_analog_meta;
   logic [15:0] ext_analog;
   logic [1:0] dropout_sync;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         ext_timing_sync <= 2'h0;
         ext_analog_meta <= 16'h0000;
         ext_analog <= 16'h0000;
         dropout_sync <= 2'h0;
      end else begin
         ext_timing_sync <= {ext_timing_sync[0], EXT_TIMING_IN};
         ext_analog_meta <= EXT_ANALOG_IN;
         ext_analog <= ext_analog_meta;
         dropout_sync <= {dropout_sync[0], ABOVE_DROPOUT_IN};
      end
   end

   // ************************************************
   // Microsecond timebase
   // ************************************************
   logic [`TLS_TICK_W-1:0] tick_cnt;
   logic tick;

   assign tick = (tick_cnt == `TLS_TICK_W'(`TLS_TICK_CYC - 1));

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         tick_cnt <= `TLS_TICK_W'(0);
      end else begin
         tick_cnt <= tick ? `TLS_TICK_W'(0) : tick_cnt + `TLS_TICK_W'(1);
      end
   end

   // ************************************************
   // Slew rate setting
   // ************************************************
   logic [39:0] slew_ps;
   logic [39:0] entered_ps;

   assign entered_ps = to_per_s(SLEW_CMD_IN.unit, SLEW_CMD_IN.value);

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         slew_ps <= `TLS_SLEW_DEF_PS;
         CAL_STATE_OUT <= 1'b1;
         SLEW_ERR_OUT <= 1'b0;
         SLEW_MIN_OUT <= `TLS_SLEW_MIN_PS;
         SLEW_MAX_OUT <= `TLS_SLEW_MAX_CC;
      end else begin
         SLEW_ERR_OUT <= 1'b0;
         // Maximum limit always follows the active mode; minimum is fixed
         SLEW_MIN_OUT <= `TLS_SLEW_MIN_PS;
         SLEW_MAX_OUT <= slew_max(MODE_IN);
         if (SLEW_CMD_IN.dflt) begin
            slew_ps <= `TLS_SLEW_DEF_PS;
            CAL_STATE_OUT <= 1'b1;
         end else if (SLEW_CMD_IN.optimum) begin
            slew_ps <= slew_max(MODE_IN);
            CAL_STATE_OUT <= 1'b0;
         end else if (SLEW_CMD_IN.wr) begin
            if (entered_ps < `TLS_SLEW_MIN_PS ||
                entered_ps > slew_max(MODE_IN)) begin
               SLEW_ERR_OUT <= 1'b1;
            end else begin
               slew_ps <= entered_ps;
               CAL_STATE_OUT <= 1'b0;
            end
         end
      end
   end

   // Bandwidth switch applies whether transients run or not
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         REDUCED_BW_OUT <= 1'b0;
      end else begin
         REDUCED_BW_OUT <=
            (48'(slew_ps) * 48'(`TLS_BW_DIV)) < 48'(slew_max(MODE_IN));
      end
   end

   // ************************************************
   // Oscillator settings, pending until cycle end
   // ************************************************
   logic [31:0] pend_period_us;
   logic [6:0] pend_duty;
   logic [31:0] cur_period_us;
   logic [6:0] cur_duty;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         pend_period_us <= `TLS_RST_PERIOD_US;
         pend_duty <= `TLS_RST_DUTY;
         RATE_ERR_OUT <= 1'b0;
         DUTY_ERR_OUT <= 1'b0;
      end else begin
         RATE_ERR_OUT <= 1'b0;
         DUTY_ERR_OUT <= 1'b0;
         if (RATE_CMD_IN.wr) begin
            if (RATE_CMD_IN.value == 32'h00000000) begin
               RATE_ERR_OUT <= 1'b1;
            end else if (RATE_CMD_IN.is_period) begin
               pend_period_us <= RATE_CMD_IN.value;
            end else begin
               // Frequency in Hz converted to the same period form
               pend_period_us <=
                  32'(`TLS_US_PER_S / 40'(RATE_CMD_IN.value));
            end
         end
         if (DUTY_WR_IN) begin
            if (DUTY_IN < `TLS_DUTY_MIN || DUTY_IN > `TLS_DUTY_MAX) begin
               DUTY_ERR_OUT <= 1'b1;
            end else begin
               pend_duty <= DUTY_IN;
            end
         end
      end
   end

   // ************************************************
   // Internal oscillator
   // ************************************************
   tls_pkg::tls_osc_t osc_state;
   logic [31:0] osc_cnt;
   logic [31:0] first_us;
   logic run_ok;
   logic run_ok_d;
   logic trans_sel;
   logic cycle_end;

   assign trans_sel = (LEVEL_SEL_IN == tls_pkg::SEL_TRANS);
   // Slow start adds the dropout condition to the start set
   assign run_ok = INPUT_ENABLE_IN && trans_sel && !EXT_TIMING_SEL_IN &&
                   (!SLOW_START_IN || dropout_sync[1]);
   assign first_us = 32'((64'(cur_period_us) * 64'(cur_duty)) /
                         64'(`TLS_PCT));
   assign cycle_end = tick && (osc_cnt + 32'h00000001 >= cur_period_us);

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         run_ok_d <= 1'b0;
      end else begin
         run_ok_d <= run_ok;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         osc_state <= tls_pkg::OSC_IDLE;
         osc_cnt <= 32'h00000000;
         cur_period_us <= `TLS_RST_PERIOD_US;
         cur_duty <= `TLS_RST_DUTY;
      end else if (!run_ok) begin
         osc_state <= tls_pkg::OSC_IDLE;
         osc_cnt <= 32'h00000000;
      end else if (!run_ok_d) begin
         // Fresh start or re-enable: new cycle, pending values apply
         osc_state <= tls_pkg::OSC_FIRST;
         osc_cnt <= 32'h00000000;
         cur_period_us <= pend_period_us;
         cur_duty <= pend_duty;
      end else if (tick) begin
         unique case (osc_state)
            tls_pkg::OSC_FIRST: begin
               osc_cnt <= osc_cnt + 32'h00000001;
               if (osc_cnt + 32'h00000001 >= first_us) begin
                  osc_state <= tls_pkg::OSC_SECOND;
               end
            end
            tls_pkg::OSC_SECOND: begin
               if (cycle_end) begin
                  osc_state <= tls_pkg::OSC_FIRST;
                  osc_cnt <= 32'h00000000;
                  cur_period_us <= pend_period_us;
                  cur_duty <= pend_duty;
               end else begin
                  osc_cnt <= osc_cnt + 32'h00000001;
               end
            end
            default: begin
               osc_state <= tls_pkg::OSC_FIRST;
               osc_cnt <= 32'h00000000;
            end
         endcase
      end
   end

   // ************************************************
   // Target selection
   // ************************************************
   logic trans_active;
   logic want_second;
   logic [15:0] target;
   logic demand_on;

   assign trans_active = trans_sel && INPUT_ENABLE_IN;
   // Slow start holds demand at zero until the source is up
   assign demand_on = INPUT_ENABLE_IN &&
                      (!SLOW_START_IN || dropout_sync[1]);

   always_comb begin
      want_second = 1'b0;
      if (trans_sel) begin
         if (EXT_TIMING_SEL_IN) begin
            want_second = ext_timing_sync[1];
         end else begin
            want_second = (osc_state == tls_pkg::OSC_SECOND);
         end
      end else begin
         want_second = (LEVEL_SEL_IN == tls_pkg::SEL_SECOND);
      end
   end

   always_comb begin
      if (!demand_on) begin
         target = 16'h0000;
      end else if (trans_sel && EXT_ANALOG_SEL_IN) begin
         target = ext_analog;
      end else if (want_second) begin
         target = LEVELS_IN.second_level;
      end else begin
         target = LEVELS_IN.first_level;
      end
   end

   // ************************************************
   // Slew limiter
   // ************************************************
   logic [31:0] setpoint;
   logic [31:0] inc_us;
   logic [63:0] inc_wide;

   // Increment per microsecond in 16.16 fixed point
   assign inc_wide = (64'(slew_ps) << `TLS_FRAC) / 64'(`TLS_US_PER_S);
   assign inc_us = (inc_wide == 64'h0) ? 32'h00000001 : inc_wide[31:0];

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         setpoint <= 32'h00000000;
      end else if (!INPUT_ENABLE_IN && !SLOW_START_IN) begin
         // Input switched off without slow stop: no demand at all
         setpoint <= 32'h00000000;
      end else if (tick) begin
         setpoint <= ramp_step(setpoint, {target, 16'h0000},
                               inc_us);
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         SETPOINT_OUT <= 16'h0000;
         TRANS_ACTIVE_OUT <= 1'b0;
      end else begin
         SETPOINT_OUT <= setpoint[31:16];
         TRANS_ACTIVE_OUT <= trans_active;
      end
   end

   // ************************************************
   // Transition time and slow slew warning
   // ************************************************
   logic [15:0] diff;
   logic [31:0] trans_us;
   logic [31:0] avail_us;
   logic [6:0] short_duty;

   assign diff = (LEVELS_IN.first_level > LEVELS_IN.second_level) ?
                 LEVELS_IN.first_level - LEVELS_IN.second_level :
                 LEVELS_IN.second_level - LEVELS_IN.first_level;
   assign trans_us = 32'((64'(diff) * 64'(`TLS_US_PER_S)) /
                         64'(slew_ps));
   assign short_duty = (cur_duty < 7'(`TLS_PCT) - cur_duty) ?
                       cur_duty : 7'(`TLS_PCT) - cur_duty;
   assign avail_us = 32'((64'(cur_period_us) * 64'(short_duty)) /
                         64'(`TLS_PCT));

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         TRANS_TIME_US_OUT <= 32'h00000000;
         SLEW_WARNING_OUT <= 1'b0;
         SLEW_PS_OUT <= `TLS_SLEW_DEF_PS;
      end else begin
         TRANS_TIME_US_OUT <= trans_us;
         SLEW_PS_OUT <= slew_ps;
         SLEW_WARNING_OUT <= trans_active &&
                             (trans_us > avail_us);
      end
   end

endmodule

// >>> verif/tb.sv
// Self-checking bench for the transient level sequencer
`timescale 1ns/1ps
`include "tls_cfg.svh"
module tb;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   tls_pkg::tls_mode_t mode = tls_pkg::constant_current_mode;
   tls_pkg::tls_levels_t lev = '0;
   tls_pkg::tls_sel_t sel = tls_pkg::SEL_FIRST;
   tls_pkg::tls_rate_cmd_t rate = '0;
   tls_pkg::tls_slew_cmd_t slew = '0;
   logic ets = 1'h0, eas = 1'h0, en = 1'h0, slow = 1'h0, dwr = 1'h0;
   logic ext_t = 1'h0, src_on = 1'h0, clr = 1'h1, above, bad;
   logic [6:0] duty = 7'h0, v;
   logic [15:0] ext_a = 16'h0, sp, max_step;
   logic bw, act, warn, cal, s_err, r_err, d_err;
   logic [31:0] ttime, r, lfsr = 32'h0001384f;
   logic [39:0] smin, smax, sps, e, keep;
   int fails = 0, cmp_count = 0, cyc = 0;
   logic [39:0] max_tab [4] = '{`TLS_SLEW_MAX_CC, `TLS_SLEW_MAX_CP,
      `TLS_SLEW_MAX_CG, `TLS_SLEW_MAX_CR};
   logic [6:0] dcase [4] = '{7'h0, 7'h1, 7'h63, 7'h64};
   logic [1:0] su [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
   logic [15:0] sv [6] = '{16'ha, 16'h1f5, 16'h1f4, 16'h1f3, 16'h0, 16'h3e8};
   logic [15:0] wv [3] = '{16'h5, 16'h4, 16'ha};
   tls_sequencer u_tls_sequencer (.MCLK_IN(clk), .RST_N_IN(rst_n),
      .MODE_IN(mode), .LEVELS_IN(lev), .LEVEL_SEL_IN(sel),
      .EXT_TIMING_SEL_IN(ets), .EXT_ANALOG_SEL_IN(eas), .INPUT_ENABLE_IN(en),
      .SLOW_START_IN(slow), .RATE_CMD_IN(rate), .DUTY_WR_IN(dwr),
      .DUTY_IN(duty), .SLEW_CMD_IN(slew), .EXT_TIMING_IN(ext_t),
      .EXT_ANALOG_IN(ext_a), .ABOVE_DROPOUT_IN(above), .SETPOINT_OUT(sp),
      .REDUCED_BW_OUT(bw), .TRANS_ACTIVE_OUT(act), .SLEW_WARNING_OUT(warn),
      .CAL_STATE_OUT(cal), .TRANS_TIME_US_OUT(ttime), .SLEW_ERR_OUT(s_err),
      .RATE_ERR_OUT(r_err), .DUTY_ERR_OUT(d_err), .SLEW_MIN_OUT(smin),
      .SLEW_MAX_OUT(smax), .SLEW_PS_OUT(sps));
   tls_stage_model u_tls_stage_model (.clk_in(clk), .src_on_in(src_on),
      .clr_in(clr), .setpoint_in(sp), .above_dropout_out(above),
      .max_step_out(max_step));
   // ******************************
   // Clock, timeout and helpers
   // ******************************
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         fails = fails + 1;
         test_done();
      end
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [39:0] slew_exp(logic [1:0] u, logic [15:0] x);
      if (u == 2'h0)
         return x * `TLS_US_PER_S;
      return u == 2'h1 ? x * `TLS_MS_PER_S : {24'h0, x};
   endfunction
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic us(int n);
      step(n * `TLS_TICK_CYC);
   endtask
   task automatic chk(string w, logic [39:0] x, logic [39:0] got);
      cmp_count++;
      if (got !== x) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", w, x, got);
      end
   endtask
   task automatic chk_rng(string w, logic [15:0] lo, hi, got);
      cmp_count++;
      if (!(got >= lo && got <= hi)) begin
         fails++;
         $display("MISMATCH %s expected %0h..%0h seen %0h", w, lo, hi, got);
      end
   endtask
   task automatic put_slew(logic d, logic o, logic [1:0] u, logic [15:0] x);
      slew = {!(d || o), d, o, u, x};
      step(1);
      slew = '0;
   endtask
   task automatic tend(string n);
      $display("test %s done", n);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ******************************
   // Main sequence
   // ******************************
   initial begin
      step(6);
      rst_n = 1'h1;
      chk("cal", 40'h1, cal);
      chk("slew_ps", `TLS_SLEW_DEF_PS, sps);
      chk("slew_max", `TLS_SLEW_MAX_CC, smax);
      chk("slew_min", `TLS_SLEW_MIN_PS, smin);
      tend("reset");
      for (int i = 0; i < 10; i++) begin
         r = rnd();
         v = i < 4 ? dcase[i] : r[6:0];
         dwr = 1'h1;
         duty = v;
         step(1);
         dwr = 1'h0;
         chk("duty_err", {39'h0, v < 7'h1 || v > 7'h63}, d_err);
      end
      duty = 7'h32;
      dwr = 1'h1;
      rate = {1'h1, 1'h1, 32'h0};
      step(1);
      dwr = 1'h0;
      chk("rate_err", 40'h1, r_err);
      rate = {1'h1, 1'h0, 32'h30d4};
      step(1);
      rate = '0;
      chk("rate_err", 40'h0, r_err);
      keep = `TLS_SLEW_DEF_PS;
      for (int i = 0; i < 6; i++) begin
         e = slew_exp(su[i], sv[i]);
         put_slew(1'h0, 1'h0, su[i], sv[i]);
         bad = e < 40'h1 || e > `TLS_SLEW_MAX_CC;
         if (!bad)
            keep = e;
         chk("slew_err", {39'h0, bad}, s_err);
         step(1);
         chk("slew_ps", keep, sps);
         chk("bw", {39'h0, keep * 40'h3e8 < `TLS_SLEW_MAX_CC}, bw);
      end
      chk("cal", 40'h0, cal);
      for (int m = 0; m < 4; m++) begin
         mode = tls_pkg::tls_mode_t'(m[1:0]);
         put_slew(1'h0, 1'h1, 2'h0, 16'h0);
         step(2);
         chk("optimum", max_tab[m], sps);
         chk("mode_max", max_tab[m], smax);
      end
      mode = tls_pkg::constant_current_mode;
      put_slew(1'h1, 1'h0, 2'h0, 16'h0);
      step(2);
      chk("cal", 40'h1, cal);
      chk("slew_ps", `TLS_SLEW_DEF_PS, sps);
      tend("settings");
      lev = {16'h64, 16'h12c};
      clr = 1'h0;
      slow = 1'h1;
      en = 1'h1;
      us(10);
      chk("slow_hold", 40'h0, sp);
      src_on = 1'h1;
      us(20);
      chk("slow_up", 40'h64, sp);
      en = 1'h0;
      us(4);
      chk_rng("slow_down", 16'h1, 16'h63, sp);
      us(16);
      chk("slow_down", 40'h0, sp);
      slow = 1'h0;
      en = 1'h1;
      sel = tls_pkg::SEL_SECOND;
      us(30);
      chk("fixed", 40'h12c, sp);
      chk("trans_time", 40'h14, ttime);
      tend("ramps");
      sel = tls_pkg::SEL_TRANS;
      us(35);
      chk("first_phase", 40'h64, sp);
      chk("active", 40'h1, act);
      us(40);
      chk("second_phase", 40'h12c, sp);
      us(40);
      chk("next_cycle", 40'h64, sp);
      for (int i = 0; i < 3; i++) begin
         put_slew(1'h0, 1'h0, 2'h0, wv[i]);
         step(4);
         chk("warning", {39'h0, i == 1}, warn);
      end
      tend("internal");
      ets = 1'h1;
      ext_t = 1'h1;
      us(30);
      chk("ext_high", 40'h12c, sp);
      ext_t = 1'h0;
      us(30);
      chk("ext_low", 40'h64, sp);
      r = rnd();
      ext_a = 16'h64 + {8'h0, r[7:0]};
      eas = 1'h1;
      us(30);
      chk("analog", {24'h0, ext_a}, sp);
      chk("max_step", 40'ha, max_step);
      sel = tls_pkg::SEL_FIRST;
      step(3);
      chk("stopped", 40'h0, act);
      us(30);
      chk("fixed_a", 40'h64, sp);
      tend("external");
      test_done();
   end
endmodule

// >>> verif/tls_sequencer_chk.sv
// Assertion checker for the transient level sequencer
`timescale 1ns/1ps
module tls_sequencer_chk (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   // Settings
   input wire tls_pkg::tls_sel_t LEVEL_SEL_IN,
   input wire logic INPUT_ENABLE_IN,
   input wire logic SLOW_START_IN,
   input wire tls_pkg::tls_rate_cmd_t RATE_CMD_IN,
   input wire logic DUTY_WR_IN,
   input wire logic [6:0] DUTY_IN,
   // Outputs
   input wire logic [15:0] SETPOINT_OUT,
   input wire logic REDUCED_BW_OUT,
   input wire logic TRANS_ACTIVE_OUT,
   input wire logic SLEW_WARNING_OUT,
   input wire logic SLEW_ERR_OUT,
   input wire logic RATE_ERR_OUT,
   input wire logic DUTY_ERR_OUT,
   input wire logic [39:0] SLEW_MAX_OUT,
   input wire logic [39:0] SLEW_PS_OUT
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);
   wire bad_duty = DUTY_IN < 7'h01 || DUTY_IN > 7'h63;
   // ******************************
   // Sequences
   // ******************************
   // Three quiet cycles let registered status catch up
   sequence settled_s;
      ($stable(SLEW_PS_OUT) && $stable(SLEW_MAX_OUT))[*3];
   endsequence
   sequence trans_on_s;
      (LEVEL_SEL_IN == tls_pkg::SEL_TRANS && INPUT_ENABLE_IN)[*2];
   endsequence
   // ******************************
   // Properties
   // ******************************
   duty_err_a: assert property (
      DUTY_WR_IN |=> DUTY_ERR_OUT == $past(bad_duty))
      else $error("duty refusal wrong");
   rate_err_a: assert property (
      RATE_CMD_IN.wr && RATE_CMD_IN.value == 32'h0 |=> RATE_ERR_OUT)
      else $error("zero rate accepted");
   slew_keep_a: assert property (
      SLEW_ERR_OUT |=> $stable(SLEW_PS_OUT))
      else $error("refused slew changed value");
   bw_select_a: assert property (
      settled_s |-> REDUCED_BW_OUT == (SLEW_PS_OUT * 40'h3e8 < SLEW_MAX_OUT))
      else $error("reduced bandwidth wrong");
   trans_on_a: assert property (
      trans_on_s |-> TRANS_ACTIVE_OUT)
      else $error("transient not active");
   trans_off_a: assert property (
      (LEVEL_SEL_IN != tls_pkg::SEL_TRANS)[*3]
      |-> !TRANS_ACTIVE_OUT && !SLEW_WARNING_OUT)
      else $error("fixed level left transient on");
   zero_off_a: assert property (
      (!INPUT_ENABLE_IN && !SLOW_START_IN)[*3] |-> SETPOINT_OUT == 16'h0)
      else $error("disabled setpoint not zero");
   ramp_step_a: assert property (
      INPUT_ENABLE_IN[*3] ##0 $changed(SETPOINT_OUT)
      |=> $stable(SETPOINT_OUT))
      else $error("setpoint moved on adjacent cycles");
endmodule
bind tls_sequencer tls_sequencer_chk u_tls_sequencer_chk (.MCLK_IN,
   .RST_N_IN, .LEVEL_SEL_IN, .INPUT_ENABLE_IN, .SLOW_START_IN,
   .RATE_CMD_IN, .DUTY_WR_IN, .DUTY_IN, .SETPOINT_OUT, .REDUCED_BW_OUT,
   .TRANS_ACTIVE_OUT, .SLEW_WARNING_OUT, .SLEW_ERR_OUT, .RATE_ERR_OUT,
   .DUTY_ERR_OUT, .SLEW_MAX_OUT, .SLEW_PS_OUT);

// >>> verif/tls_stage_model.sv
// Power stage and source model facing the sequencer
`timescale 1ns/1ps
module tls_stage_model (
   input wire logic clk_in,
   input wire logic src_on_in,
   input wire logic clr_in,
   input wire logic [15:0] setpoint_in,
   output logic above_dropout_out,
   output logic [15:0] max_step_out
);
   logic [15:0] last;
   logic [15:0] d;
   assign d = setpoint_in > last ? setpoint_in - last : last - setpoint_in;
   // Largest demand jump the stage was asked to follow
   always_ff @(posedge clk_in) begin
      last <= setpoint_in;
      above_dropout_out <= src_on_in;
      if (clr_in)
         max_step_out <= 16'h0;
      else if (d > max_step_out)
         max_step_out <= d;
   end
endmodule
